// File: rtl/waveform_upload_responder.sv
`timescale 1ns/1ps
module waveform_upload_responder import upload_pkg::*; #(
	parameter int REPEAT_TICKS = REPEAT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic readCmd,
	input wire logic readRepeatCmd,
	input wire buf_t readType,
	input wire logic textFrame,
	input wire logic zoomCmd,
	input wire logic zoomArg,
	input wire logic zoomQuery,
	input wire logic rfOn,
	input wire logic peakHoldOn,
	input wire logic dacOn,
	input wire logic [7:0] sampleData,
	input wire logic txReady,
	output buf_t sampleBuf,
	output logic [8:0] sampleAddr,
	output logic [7:0] txData,
	output logic txValid,
	output logic busy,
	output logic repeatOn,
	output logic zoomOn
);
	function automatic logic [7:0] pick(input logic [135:0] v,
		input logic [8:0] len, input logic [8:0] i);
		pick = v[8 * (len - 9'h001 - i) +: 8];
	endfunction

	function automatic logic bufActive(input buf_t b, input logic rf,
		input logic pk, input logic dc);
		case (b)
			BUF_RF: bufActive = rf;
			BUF_PEAK: bufActive = pk;
			BUF_DAC: bufActive = dc;
			default: bufActive = 1'b1;
		endcase
	endfunction

	state_t state_q;
	seg_t seg_q;
	logic [8:0] idx_q, line_q, sampleIdx_q;
	buf_t jobBuf_q, repeatBuf_q;
	logic jobText_q, repeatText_q, pendTick_q, tick;

	// start arbitration: zoom query, then host read, then periodic resend
	wire isIdle = state_q == ST_IDLE;
	wire anyRead = readCmd || readRepeatCmd;
	wire startZoom = isIdle && zoomQuery;
	wire startRead = isIdle && !zoomQuery && anyRead;
	wire startRepeat = isIdle && !zoomQuery && !anyRead && pendTick_q &&
		repeatOn;
	wire start = startZoom || startRead || startRepeat;
	wire buf_t startBuf = startRead ? readType : repeatBuf_q;
	wire startText = startRead ? textFrame : repeatText_q;
	wire startOk = bufActive(startBuf, rfOn, peakHoldOn, dacOn);
	wire seg_t startSeg = startZoom ? SEG_ZOOM :
		(startOk ? SEG_NAME : SEG_ERR);
	wire cancel = readCmd && repeatOn && readType == repeatBuf_q;

	// per-job framing values
	wire isRf = jobBuf_q == BUF_RF;
	wire [8:0] nLen = isRf ? LEN_RF : LEN_SHORT;
	wire [8:0] nLines = isRf ? LINES_RF : LINES_SHORT;
	wire [135:0] cntText = isRf ? TXT_CNT_RF : TXT_CNT_SHORT;
	logic [135:0] nameText;
	logic [8:0] nameLen, segLen;
	always_comb begin
		case (jobBuf_q)
			BUF_RF: begin
				nameText = TXT_RF;
				nameLen = LEN_RF_NAME;
			end
			BUF_PEAK: begin
				nameText = TXT_PEAK;
				nameLen = LEN_PEAK_NAME;
			end
			BUF_DAC: begin
				nameText = TXT_DAC;
				nameLen = LEN_DAC_NAME;
			end
			default: begin
				nameText = TXT_TRACE;
				nameLen = LEN_TRACE_NAME;
			end
		endcase
	end

	always_comb begin
		case (seg_q)
			SEG_NAME: segLen = nameLen;
			SEG_HASH: segLen = HASH_LEN;
			SEG_COUNT: segLen = COUNT_LEN;
			SEG_BIN: segLen = nLen;
			SEG_HEAD: segLen = HEAD_LEN - nameLen;
			SEG_LINE: segLen = LINE_LEN;
			SEG_TAIL: segLen = TAIL_LEN;
			SEG_ERR: segLen = ERR_LEN;
			SEG_ZOOM: segLen = zoomOn ? ZOOM_ON_LEN : ZOOM_OFF_LEN;
			default: segLen = EOT_LEN;
		endcase
	end

	// byte generation; samples are offset, then raw or split in two digits
	wire [7:0] sent = sampleData + SAMPLE_OFFSET;
	wire [3:0] nib = idx_q[0] ? sent[3:0] : sent[7:4];
	wire [7:0] nibChar = DIGIT_BASE + {4'h0, nib};
	wire inData = idx_q < LINE_DATA;
	logic [7:0] curByte;
	always_comb begin
		case (seg_q)
			SEG_NAME: curByte = pick(nameText, nameLen, idx_q);
			SEG_HASH: curByte = pick(TXT_HASH, HASH_LEN, idx_q);
			SEG_COUNT: curByte = pick(cntText, COUNT_LEN, idx_q);
			SEG_BIN: curByte = sent;
			SEG_HEAD: begin
				if (idx_q < BEGIN_LEN)
					curByte = pick(TXT_BEGIN, BEGIN_LEN, idx_q);
				else if (idx_q == segLen - 9'h002)
					curByte = CR_CHAR;
				else if (idx_q == segLen - 9'h001)
					curByte = LF_CHAR;
				else
					curByte = SPACE_CHAR;
			end
			SEG_LINE: curByte = inData ? nibChar :
				(idx_q == LINE_DATA ? CR_CHAR : LF_CHAR);
			SEG_TAIL: curByte = pick(TXT_TAIL, TAIL_LEN, idx_q);
			SEG_ERR: curByte = pick(TXT_ERR, ERR_LEN, idx_q);
			SEG_ZOOM: curByte = zoomOn ?
				pick(TXT_ZOOM_ON, ZOOM_ON_LEN, idx_q) :
				pick(TXT_ZOOM_OFF, ZOOM_OFF_LEN, idx_q);
			default: curByte = EOT_CHAR;
		endcase
	end

	// segment sequencing
	wire accept = state_q == ST_SEND && txReady;
	wire segEnd = idx_q == segLen - 9'h001;
	wire lastLine = line_q == nLines - 9'h001;
	wire step = seg_q == SEG_BIN ||
		(seg_q == SEG_LINE && inData && idx_q[0]);
	logic [3:0] nextSeg;
	logic jobDone;
	always_comb begin
		jobDone = 1'b0;
		case (seg_q)
			SEG_NAME: nextSeg = jobText_q ? SEG_HEAD : SEG_HASH;
			SEG_HASH: nextSeg = SEG_COUNT;
			SEG_COUNT: nextSeg = SEG_BIN;
			SEG_BIN: nextSeg = SEG_EOT;
			SEG_HEAD: nextSeg = SEG_LINE;
			SEG_LINE: nextSeg = lastLine ? SEG_TAIL : SEG_LINE;
			default: begin
				nextSeg = SEG_EOT;
				jobDone = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			busy <= 1'b0;
			txValid <= 1'b0;
			txData <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: if (start) begin
					state_q <= ST_FETCH;
					busy <= 1'b1;
				end
				ST_FETCH: state_q <= ST_LOAD;
				ST_LOAD: begin
					state_q <= ST_SEND;
					txData <= curByte;
					txValid <= 1'b1;
				end
				ST_SEND: if (txReady) begin
					txValid <= 1'b0;
					state_q <= (segEnd && jobDone) ? ST_IDLE : ST_FETCH;
					busy <= !(segEnd && jobDone);
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			seg_q <= SEG_NAME;
			idx_q <= 9'h000;
			line_q <= 9'h000;
			sampleIdx_q <= 9'h000;
			jobBuf_q <= BUF_TRACE;
			jobText_q <= 1'b0;
		end else if (start) begin
			seg_q <= startSeg;
			idx_q <= 9'h000;
			line_q <= 9'h000;
			sampleIdx_q <= 9'h000;
			jobBuf_q <= startBuf;
			jobText_q <= startText;
		end else if (accept) begin
			sampleIdx_q <= sampleIdx_q + {8'h00, step};
			idx_q <= segEnd ? 9'h000 : idx_q + 9'h001;
			if (segEnd) begin
				seg_q <= nextSeg;
				line_q <= seg_q == SEG_LINE ? line_q + 9'h001 : 9'h000;
			end
		end
	end

	// max values sit at 0..219 and min values at 220..439 of the RF store
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sampleAddr <= 9'h000;
			sampleBuf <= BUF_TRACE;
		end else if (state_q == ST_FETCH) begin
			sampleAddr <= sampleIdx_q;
			sampleBuf <= jobBuf_q;
		end
	end

	pulse_divider #(
		.PERIOD(REPEAT_TICKS)
	) secondTick (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.clear(readRepeatCmd),
		.tick(tick)
	);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			repeatOn <= 1'b0;
			repeatBuf_q <= BUF_TRACE;
			repeatText_q <= 1'b0;
			pendTick_q <= 1'b0;
			zoomOn <= 1'b0;
		end else begin
			if (readRepeatCmd) begin
				repeatOn <= 1'b1;
				repeatBuf_q <= readType;
				repeatText_q <= textFrame;
			end else if (cancel) begin
				repeatOn <= 1'b0;
			end
			if (tick && repeatOn)
				pendTick_q <= 1'b1;
			else if (startRepeat || !repeatOn)
				pendTick_q <= 1'b0;
			if (zoomCmd)
				zoomOn <= zoomArg;
		end
	end

	offset_add_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(state_q == ST_LOAD && seg_q == SEG_BIN) |=>
		txData == 8'($past(sampleData) + SAMPLE_OFFSET))
		else $error("sample byte not offset by 28");
	error_path_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(startRead && !startOk) |=> seg_q == SEG_ERR && state_q == ST_FETCH)
		else $error("inactive buffer did not give an error");
	error_clean_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(seg_q == SEG_ERR && accept && segEnd) |=> state_q == ST_IDLE)
		else $error("error answer went on past its end");
	frame_order_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(accept && segEnd && seg_q == SEG_NAME && !jobText_q) |=>
		seg_q == SEG_HASH ##3 txData == ",")
		else $error("comma does not follow name");
	sample_count_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(accept && segEnd && seg_q == SEG_BIN) |=>
		sampleIdx_q == nLen && seg_q == SEG_EOT)
		else $error("wrong number of samples sent");
	line_end_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(state_q == ST_LOAD && seg_q == SEG_LINE && idx_q == LINE_DATA) |=>
		txData == CR_CHAR && txValid)
		else $error("data line not closed by CR after 40 chars");
	zoom_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		zoomCmd |=> zoomOn == $past(zoomArg))
		else $error("zoom state not taken");
	zoom_reply_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		startZoom |=> seg_q == SEG_ZOOM ##2 txData == "Z")
		else $error("zoom query not answered");
	repeat_stop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(cancel && !readRepeatCmd) |=>
		!repeatOn ##1 (!repeatOn || $past(readRepeatCmd)))
		else $error("repeat not cancelled");
	repeat_arm_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(tick && repeatOn && !cancel && !readRepeatCmd) |=> pendTick_q)
		else $error("second tick lost");
endmodule

// File: common/upload_pkg.sv
// Operation
// - a single-shot read command sends the requested buffer once.
// - buffers hold 220 samples, RF holds 440 (220 max then 220 min).
// - each 8-bit sample has 28 added before it is sent.
// - in the read response samples go out as raw binary bytes.
// - a request for a buffer whose function is off returns an error.
// - response order is name, comma, #9, nine-digit count, samples, EOT.
// - the repeating read resends the buffer once per second.
// - a single-shot read of the same type stops the repeating uploads.
// - text packet: 40-char header line, lines of 20 samples, end line.
// - the DAC text packet holds 220 samples in 11 lines of 20.
// - the zoom command turns the magnified view on or off.
// - the zoom query answers with the zoom keyword and ON or OFF.
// - the RF text packet sends the 220 max values before the 220 min.
package upload_pkg;
	localparam int CLK_HZ = 200_000_000;
	localparam int REPEAT_PERIOD_S = 1;
	localparam int REPEAT_CYCLES = CLK_HZ * REPEAT_PERIOD_S;

	typedef logic [1:0] buf_t;
	localparam buf_t BUF_TRACE = 2'h0;
	localparam buf_t BUF_RF = 2'h1;
	localparam buf_t BUF_PEAK = 2'h2;
	localparam buf_t BUF_DAC = 2'h3;

	typedef logic [3:0] seg_t;
	localparam seg_t SEG_NAME = 4'h0;
	localparam seg_t SEG_HASH = 4'h1;
	localparam seg_t SEG_COUNT = 4'h2;
	localparam seg_t SEG_BIN = 4'h3;
	localparam seg_t SEG_EOT = 4'h4;
	localparam seg_t SEG_HEAD = 4'h5;
	localparam seg_t SEG_LINE = 4'h6;
	localparam seg_t SEG_TAIL = 4'h7;
	localparam seg_t SEG_ERR = 4'h8;
	localparam seg_t SEG_ZOOM = 4'h9;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FETCH = 4'h2,
		ST_LOAD = 4'h4,
		ST_SEND = 4'h8
	} state_t;

	localparam logic [8:0] LEN_SHORT = 9'h0DC;
	localparam logic [8:0] LEN_RF = 9'h1B8;
	localparam logic [8:0] LINES_SHORT = 9'h00B;
	localparam logic [8:0] LINES_RF = 9'h016;
	localparam logic [8:0] LINE_DATA = 9'h028;
	localparam logic [8:0] LINE_LEN = 9'h02A;
	localparam logic [8:0] HEAD_LEN = 9'h02A;
	localparam logic [8:0] BEGIN_LEN = 9'h00F;
	localparam logic [8:0] TAIL_LEN = 9'h011;
	localparam logic [8:0] ERR_LEN = 9'h006;
	localparam logic [8:0] HASH_LEN = 9'h003;
	localparam logic [8:0] COUNT_LEN = 9'h009;
	localparam logic [8:0] EOT_LEN = 9'h001;
	localparam logic [8:0] ZOOM_ON_LEN = 9'h009;
	localparam logic [8:0] ZOOM_OFF_LEN = 9'h00A;
	localparam logic [8:0] LEN_TRACE_NAME = 9'h005;
	localparam logic [8:0] LEN_RF_NAME = 9'h002;
	localparam logic [8:0] LEN_PEAK_NAME = 9'h007;
	localparam logic [8:0] LEN_DAC_NAME = 9'h003;

	localparam logic [7:0] SAMPLE_OFFSET = 8'h1C;
	localparam logic [7:0] EOT_CHAR = 8'h04;
	localparam logic [7:0] CR_CHAR = 8'h0D;
	localparam logic [7:0] LF_CHAR = 8'h0A;
	localparam logic [7:0] SPACE_CHAR = 8'h20;
	localparam logic [7:0] DIGIT_BASE = 8'h30;

	localparam logic [135:0] TXT_TRACE = 136'(40'h415343414E);
	localparam logic [135:0] TXT_RF = 136'(16'h5246);
	localparam logic [135:0] TXT_PEAK = 136'(56'h5045414B4D454D);
	localparam logic [135:0] TXT_DAC = 136'(24'h444143);
	localparam logic [135:0] TXT_HASH = 136'(",#9");
	localparam logic [135:0] TXT_CNT_SHORT = 136'("000000220");
	localparam logic [135:0] TXT_CNT_RF = 136'("000000440");
	localparam logic [135:0] TXT_BEGIN = 136'("_Waveform_BEGIN");
	localparam logic [135:0] TXT_TAIL = 136'({"OK_Waveform_END", CR_CHAR,
		LF_CHAR});
	localparam logic [135:0] TXT_ERR = 136'({"ERROR", EOT_CHAR});
	localparam logic [135:0] TXT_ZOOM_ON = 136'({"ZOOM ON", CR_CHAR,
		LF_CHAR});
	localparam logic [135:0] TXT_ZOOM_OFF = 136'({"ZOOM OFF", CR_CHAR,
		LF_CHAR});
endpackage

// File: rtl/pulse_divider.sv
`timescale 1ns/1ps
module pulse_divider #(
	parameter int PERIOD = 2
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clear,
	output logic tick
);
	localparam int W = $clog2(PERIOD);
	localparam logic [W-1:0] LAST = W'(PERIOD - 1);
	logic [W-1:0] count_q;
	wire atLast = count_q == LAST;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			count_q <= '0;
			tick <= 1'b0;
		end else begin
			count_q <= (clear || atLast) ? '0 : count_q + 1'b1;
			tick <= atLast && !clear;
		end
	end
endmodule

// File: bench/host_sink.sv
`timescale 1ns/1ps
module host_sink (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic slow,
	output logic txReady
);
	logic [7:0] got[$];
	logic [1:0] phase_q;
	// when slow, ready one cycle in four so every byte after the first stalls
	assign txReady = !slow || (phase_q == 2'h0);
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
			if (txValid && txReady) begin
				got.push_back(txData);
			end
		end
	end
endmodule

// File: bench/waveform_upload_responder_tb_top.sv
`timescale 1ns/1ps
module waveform_upload_responder_tb_top;
	import upload_pkg::*;
	localparam int TICKS = 2000;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic readCmd = 1'b0, readRepeatCmd = 1'b0, textFrame = 1'b0;
	logic zoomCmd = 1'b0, zoomArg = 1'b0, zoomQuery = 1'b0, slow = 1'b0;
	logic rfOn = 1'b1, peakHoldOn = 1'b0, dacOn = 1'b1;
	buf_t readType = BUF_TRACE;
	buf_t sampleBuf;
	logic [8:0] sampleAddr;
	logic [7:0] sampleData, txData;
	logic txValid, txReady, busy, repeatOn, zoomOn;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	logic [7:0] expq[$];

	always #2.5 clk_sys = ~clk_sys;

	// stored samples stay within 0..199
	function automatic logic [7:0] raw(input buf_t t, input logic [8:0] a);
		return 8'((10'(a) + 10'(t) * 10'h007) % 10'h0C8);
	endfunction
	assign sampleData = raw(sampleBuf, sampleAddr);

	waveform_upload_responder #(.REPEAT_TICKS(TICKS)) uut (
		.clk_sys(clk_sys), .nrst(nrst), .readCmd(readCmd),
		.readRepeatCmd(readRepeatCmd), .readType(readType),
		.textFrame(textFrame), .zoomCmd(zoomCmd), .zoomArg(zoomArg),
		.zoomQuery(zoomQuery), .rfOn(rfOn), .peakHoldOn(peakHoldOn),
		.dacOn(dacOn), .sampleData(sampleData), .txReady(txReady),
		.sampleBuf(sampleBuf), .sampleAddr(sampleAddr), .txData(txData),
		.txValid(txValid), .busy(busy), .repeatOn(repeatOn),
		.zoomOn(zoomOn)
	);
	host_sink host (
		.clk_sys(clk_sys), .nrst(nrst), .txData(txData),
		.txValid(txValid), .slow(slow), .txReady(txReady)
	);

	task automatic close_out();
		$display("compares %0d mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic put_txt(input logic [135:0] s, input int n);
		for (int k = n - 1; k >= 0; k--) begin
			expq.push_back(s[k*8 +: 8]);
		end
	endtask

	task automatic build(input buf_t t, input logic txt, input logic err);
		logic [135:0] nm;
		int nl;
		int ns;
		logic [7:0] v;
		expq.delete();
		nm = (t == BUF_TRACE) ? TXT_TRACE : (t == BUF_RF) ? TXT_RF :
			(t == BUF_PEAK) ? TXT_PEAK : TXT_DAC;
		nl = (t == BUF_TRACE) ? 5 : (t == BUF_RF) ? 2 : (t == BUF_PEAK) ? 7 : 3;
		ns = (t == BUF_RF) ? 440 : 220;
		if (err) begin
			put_txt(TXT_ERR, 6);
		end else if (!txt) begin
			put_txt(nm, nl);
			put_txt(TXT_HASH, 3);
			put_txt((t == BUF_RF) ? TXT_CNT_RF : TXT_CNT_SHORT, 9);
			for (int i = 0; i < ns; i++) begin
				expq.push_back(raw(t, 9'(i)) + 8'h1C);
			end
			expq.push_back(8'h04);
		end else begin
			put_txt(nm, nl);
			put_txt(TXT_BEGIN, 15);
			repeat (40 - nl - 15) expq.push_back(8'h20);
			put_txt({8'h0D, 8'h0A}, 2);
			for (int i = 0; i < ns; i++) begin
				v = raw(t, 9'(i)) + 8'h1C;
				expq.push_back(8'h30 + {4'h0, v[7:4]});
				expq.push_back(8'h30 + {4'h0, v[3:0]});
				if (i % 20 == 19) begin
					put_txt({8'h0D, 8'h0A}, 2);
				end
			end
			put_txt(TXT_TAIL, 17);
		end
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		@(negedge clk_sys);
		while (busy === 1'b1 && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
	endtask

	// kind 0 single read, 1 repeating read, 2 zoom query
	task automatic run_cmd(input int kind, input buf_t t, input logic txt);
		host.got.delete();
		@(negedge clk_sys);
		readType = t;
		textFrame = txt;
		readCmd = (kind == 0);
		readRepeatCmd = (kind == 1);
		zoomQuery = (kind == 2);
		@(negedge clk_sys);
		readCmd = 1'b0;
		readRepeatCmd = 1'b0;
		zoomQuery = 1'b0;
		wait_idle();
	endtask

	task automatic cmp_frame();
		chk(16'(host.got.size()), 16'(expq.size()));
		for (int i = 0; i < expq.size() && i < host.got.size(); i++) begin
			chk({8'h00, host.got[i]}, {8'h00, expq[i]});
		end
	endtask

	task automatic sc_read(input buf_t t, input logic txt, input logic err);
		build(t, txt, err);
		run_cmd(0, t, txt);
		cmp_frame();
	endtask

	task automatic sc_zoom(input logic on);
		@(negedge clk_sys);
		zoomCmd = 1'b1;
		zoomArg = on;
		@(negedge clk_sys);
		zoomCmd = 1'b0;
		@(negedge clk_sys);
		chk({15'h0000, zoomOn}, {15'h0000, on});
		expq.delete();
		put_txt(on ? TXT_ZOOM_ON : TXT_ZOOM_OFF, on ? 9 : 10);
		run_cmd(2, BUF_TRACE, 1'b0);
		cmp_frame();
	endtask

	task automatic sc_repeat();
		int start;
		int n;
		start = cycles;
		build(BUF_TRACE, 1'b0, 1'b0);
		run_cmd(1, BUF_TRACE, 1'b0);
		chk({15'h0000, repeatOn}, 16'h0001);
		cmp_frame();
		host.got.delete();
		n = 0;
		while (busy !== 1'b1 && n < TICKS * 2) begin
			@(negedge clk_sys);
			n++;
		end
		// resend starts about one period after the command
		chk({15'h0000, (cycles - start >= TICKS) &&
			(cycles - start <= TICKS + 4)}, 16'h0001);
		wait_idle();
		cmp_frame();
		run_cmd(0, BUF_TRACE, 1'b0);
		chk({15'h0000, repeatOn}, 16'h0000);
		cmp_frame();
		host.got.delete();
		n = 0;
		repeat (TICKS * 2) begin
			@(negedge clk_sys);
			n += (busy === 1'b1) ? 1 : 0;
		end
		chk(16'(n), 16'h0000);
		chk(16'(host.got.size()), 16'h0000);
	endtask

	initial begin
		repeat (3) @(negedge clk_sys);
		nrst = 1'b1;
		chk({14'h0000, busy, txValid}, 16'h0000);
		sc_read(BUF_TRACE, 1'b0, 1'b0);
		sc_read(BUF_RF, 1'b0, 1'b0);
		sc_read(BUF_PEAK, 1'b0, 1'b1);
		peakHoldOn = 1'b1;
		sc_read(BUF_PEAK, 1'b1, 1'b0);
		slow = 1'b1;
		sc_read(BUF_DAC, 1'b1, 1'b0);
		slow = 1'b0;
		sc_read(BUF_RF, 1'b1, 1'b0);
		dacOn = 1'b0;
		sc_read(BUF_DAC, 1'b0, 1'b1);
		sc_zoom(1'b1);
		sc_zoom(1'b0);
		sc_repeat();
		close_out();
	end
endmodule
